// ===== hdl/lpt_defines.vh
// Purpose: Constants for the panel timing generator
// Assumes: aclk is the internal panel clock source, 100 MHz
// Notes:   Register byte offsets, control fields, raster figures
`ifndef LPT_DEFINES_VH
`define LPT_DEFINES_VH

// ****************************************
// Raster figures, horizontal in panel clock cycles, vertical in lines
// ****************************************
`define LPT_H_TOTAL      11'h400
`define LPT_H_ACT        10'h320
`define LPT_H_BP         10'h02e
`define LPT_H_SYNC       10'h014
`define LPT_V_TOTAL      11'h20d
`define LPT_V_ACT        10'h1e0
`define LPT_V_BP         10'h017
`define LPT_V_SYNC       10'h00a
`define LPT_STRIDE       32'h0000_0320
`define LPT_CLK_DIV      4'h8

// ****************************************
// Colours
// ****************************************
`define LPT_OUT_BG_RGB   24'h00_0000
`define LPT_OUT_BG_A     8'hff
`define LPT_LAYER_BG_RGB 24'hff_ffff
`define LPT_LAYER_BG_A   8'hff
`define LPT_REPEAT_CNT   8'h00
`define LPT_FADE_SPEED   8'h00

// ****************************************
// Register map
// ****************************************
`define LPT_REG_CTRL     6'h00
`define LPT_REG_BUF0     6'h04
`define LPT_REG_BUF1     6'h08
`define LPT_REG_ADJ      6'h0c
`define LPT_REG_STATUS   6'h10
`define LPT_REG_FRAMES   6'h14
`define LPT_CTRL_RESET   32'h0000_0000
`define LPT_ADJ_RESET    32'h0000_8000
`define LPT_CTRL_EN      0
`define LPT_CTRL_BUF     1
`define LPT_CTRL_LAYER   2
`define LPT_CTRL_BC      3
`define LPT_CTRL_GAMMA   4
`define LPT_RESP_OKAY    2'h0
`define LPT_RESP_DECERR  2'h3

`endif

// ===== hdl/lpt_timing_gen.v
// Purpose: Raster timing and pixel output for an 800x480 RGB panel
// Assumes: Frame memory answers a read one aclk after fb_rd
// Notes:   Panel clock is aclk divided by eight, driven out
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "lpt_defines.vh"

// Behaviour
// - Each line lasts 1024 panel clocks including sync and porches.
// - Active pixel data is driven for 800 panel clocks per line.
// - Horizontal back porch of 46 clocks follows sync before pixels.
// - Horizontal sync is low for 20 panel clocks each line.
// - Each frame spans 525 line periods.
// - Active video appears on 480 lines per frame.
// - Vertical back porch of 23 lines follows vertical sync.
// - Vertical sync is low for 10 line periods each frame.
// - Data enable is high only while an active pixel shows.
// - Pixels leave as 24 bits, red, green, blue, little endian.
// - Uncovered positions show background black, alpha 255.
// - The layer is fetched as an 800 by 480 image.
// - Fetch address steps 800 pixels from one line to the next.
// - Input pixels are RGB565, expanded to 24-bit colour.
// - One of two buffers is scanned; software selects which.
// - The layer's top-left pixel sits at display position 0,0.
// - Layer background colour is alpha, red, green, blue all 255.
// - Each line read once, no repeat, no fading.
// - Panel clock is the internal source divided by eight.
// - Hsync on output 0, vsync on output 1, enable on output 2.
// - Brightness and contrast act before gamma correction.
module lpt_timing_gen (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] fb_addr,
  output reg         fb_rd,
  input  wire [15:0] fb_rdata,
  output reg         panel_clk,
  output reg         timing_out_0,
  output reg         timing_out_1,
  output reg         timing_out_2,
  output reg  [23:0] pix_rgb
);

  // ****************************************
  // Functions
  // ****************************************
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = din[i*8 +: 8];
        end
      end
    end
  endfunction

  // Contrast gain 0x80 is unity, brightness is signed
  function [7:0] bc_adj;
    input [7:0] x;
    input [7:0] bright;
    input [7:0] gain;
    reg   [15:0] prod;
    reg   signed [10:0] sum;
    begin
      prod = x * gain;
      sum  = $signed({2'b00, prod[15:7]}) + $signed({{3{bright[7]}}, bright});
      if (sum < 0) begin
        bc_adj = 8'h00;
      end else if (sum > 255) begin
        bc_adj = 8'hff;
      end else begin
        bc_adj = sum[7:0];
      end
    end
  endfunction

  // Gamma of two
  function [7:0] gamma_adj;
    input [7:0] x;
    reg   [15:0] sq;
    begin
      sq        = x * x;
      gamma_adj = sq[15:8];
    end
  endfunction

  // ****************************************
  // Registers and bus state
  // ****************************************
  reg  [31:0] ctrl;
  reg  [31:0] buf0_base;
  reg  [31:0] buf1_base;
  reg  [31:0] adj;
  reg  [31:0] frame_cnt;
  reg         shown_buf;
  reg         aw_held;
  reg  [5:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;

  wire        en        = ctrl[`LPT_CTRL_EN];
  wire        do_write  = aw_held && w_held && !s_axi_bvalid;
  wire        do_read   = s_axi_arvalid && s_axi_arready;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // ****************************************
  // Raster state
  // ****************************************
  reg  [2:0]  div;
  reg  [9:0]  hcnt;
  reg  [9:0]  vcnt;
  reg  [31:0] line_base;
  reg  [15:0] pix_in;
  reg  [23:0] pix_bc;
  reg  [23:0] pix_fin;

  wire        tick      = (div == 3'h7);
  wire [9:0]  h_act_beg = `LPT_H_SYNC + `LPT_H_BP;
  wire [9:0]  h_act_end = h_act_beg + `LPT_H_ACT;
  wire [9:0]  v_act_beg = `LPT_V_SYNC + `LPT_V_BP;
  wire [9:0]  v_act_end = v_act_beg + `LPT_V_ACT;
  wire        h_last    = ({1'b0, hcnt} == `LPT_H_TOTAL - 11'h001);
  wire        v_last    = ({1'b0, vcnt} == `LPT_V_TOTAL - 11'h001);
  wire        h_act     = (hcnt >= h_act_beg) && (hcnt < h_act_end);
  wire        v_act     = (vcnt >= v_act_beg) && (vcnt < v_act_end);
  // Fetch leads the shown pixel by one panel period
  wire        h_pre     = (hcnt >= h_act_beg - 10'h001) && (hcnt < h_act_end - 10'h001);
  wire        active    = en && h_pre && v_act;
  wire        layer_on  = ctrl[`LPT_CTRL_LAYER];
  wire [9:0]  col       = hcnt - (h_act_beg - 10'h001);
  wire [31:0] cur_base  = shown_buf ? buf1_base : buf0_base;
  wire [23:0] expanded;
  wire [23:0] adjusted;
  wire [23:0] corrected;

  // ****************************************
  // Write channel
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      aw_addr      <= 6'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LPT_RESP_OKAY;
      ctrl         <= `LPT_CTRL_RESET;
      buf0_base    <= 32'h0000_0000;
      buf1_base    <= 32'h0000_0000;
      adj          <= `LPT_ADJ_RESET;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `LPT_RESP_OKAY;
        case (aw_addr)
          `LPT_REG_CTRL: begin
            ctrl <= merge(ctrl, w_data, w_strb);
          end
          `LPT_REG_BUF0: begin
            buf0_base <= merge(buf0_base, w_data, w_strb);
          end
          `LPT_REG_BUF1: begin
            buf1_base <= merge(buf1_base, w_data, w_strb);
          end
          `LPT_REG_ADJ: begin
            adj <= merge(adj, w_data, w_strb);
          end
          `LPT_REG_STATUS, `LPT_REG_FRAMES: begin
            s_axi_bresp <= `LPT_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `LPT_RESP_DECERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always @* begin
    next_rresp = `LPT_RESP_OKAY;
    next_rdata = 32'h0000_0000;
    case (s_axi_araddr)
      `LPT_REG_CTRL: begin
        next_rdata = ctrl;
      end
      `LPT_REG_BUF0: begin
        next_rdata = buf0_base;
      end
      `LPT_REG_BUF1: begin
        next_rdata = buf1_base;
      end
      `LPT_REG_ADJ: begin
        next_rdata = adj;
      end
      `LPT_REG_STATUS: begin
        next_rdata = {14'h0000, v_act, shown_buf, 6'h00, vcnt};
      end
      `LPT_REG_FRAMES: begin
        next_rdata = frame_cnt;
      end
      default: begin
        next_rresp = `LPT_RESP_DECERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LPT_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Panel clock divider
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn || !en) begin
      div       <= 3'h0;
      panel_clk <= 1'b0;
    end else begin
      div       <= div + 3'h1;
      panel_clk <= (div >= 3'h3) && (div < 3'h7);
    end
  end

  // ****************************************
  // Line and frame counters
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn || !en) begin
      hcnt      <= 10'h000;
      vcnt      <= 10'h000;
      line_base <= 32'h0000_0000;
      frame_cnt <= frame_cnt;
      shown_buf <= ctrl[`LPT_CTRL_BUF];
      if (!aresetn) begin
        frame_cnt <= 32'h0000_0000;
        shown_buf <= 1'b0;
      end
    end else if (tick) begin
      if (h_last) begin
        hcnt <= 10'h000;
        if (v_act) begin
          line_base <= line_base + `LPT_STRIDE;
        end
        if (v_last) begin
          vcnt      <= 10'h000;
          line_base <= 32'h0000_0000;
          frame_cnt <= frame_cnt + 32'h0000_0001;
          // Swap only between frames, or while the raster is disabled, to avoid tearing
          shown_buf <= ctrl[`LPT_CTRL_BUF];
        end else begin
          vcnt <= vcnt + 10'h001;
        end
      end else begin
        hcnt <= hcnt + 10'h001;
      end
    end
  end

  // ****************************************
  // Fetch and pixel pipeline
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      fb_rd   <= 1'b0;
      fb_addr <= 32'h0000_0000;
      pix_in  <= 16'h0000;
      pix_bc  <= 24'h00_0000;
      pix_fin <= 24'h00_0000;
    end else begin
      // Layer at 0,0, 800x480, one read per pixel
      fb_rd <= active && layer_on && (div == 3'h7);
      if (active && (div == 3'h7)) begin
        fb_addr <= cur_base + line_base + {22'h00_0000, col};
      end
      if (fb_rd) begin
        pix_in <= fb_rdata;
      end
      if (div == 3'h2) begin
        pix_bc <= adjusted;
      end
      if (div == 3'h3) begin
        pix_fin <= corrected;
      end
    end
  end

  // RGB565 widened by repeating high bits
  assign expanded = {pix_in[4:0], pix_in[4:2],
                     pix_in[10:5], pix_in[10:9],
                     pix_in[15:11], pix_in[15:13]};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : chan
      assign adjusted[g*8 +: 8] = ctrl[`LPT_CTRL_BC] ?
        bc_adj(expanded[g*8 +: 8], adj[7:0], adj[15:8]) :
        expanded[g*8 +: 8];
      assign corrected[g*8 +: 8] = ctrl[`LPT_CTRL_GAMMA] ?
        gamma_adj(pix_bc[g*8 +: 8]) : pix_bc[g*8 +: 8];
    end
  endgenerate

  // ****************************************
  // Panel outputs
  // ****************************************
  // Outputs lag counters by one panel period, all alike
  always @(posedge aclk) begin
    if (!aresetn || !en) begin
      timing_out_0 <= 1'b1;
      timing_out_1 <= 1'b1;
      timing_out_2 <= 1'b0;
      pix_rgb      <= `LPT_OUT_BG_RGB;
    end else if (tick) begin
      timing_out_0 <= !(hcnt < `LPT_H_SYNC);
      timing_out_1 <= !(vcnt < `LPT_V_SYNC);
      timing_out_2 <= h_act && v_act;
      if (!(h_act && v_act)) begin
        pix_rgb <= `LPT_OUT_BG_RGB;
      end else if (!layer_on) begin
        pix_rgb <= `LPT_LAYER_BG_RGB;
      end else begin
        pix_rgb <= pix_fin;
      end
    end
  end

endmodule

// ===== sim/lpt_fb_mem.sv
// Purpose: Frame memory partner, answers while the read strobe stands
// Assumes: Pixel value is a function of the word address
// Notes:   Between reads the data lines toggle, never hold
`timescale 1ns/1ns
module lpt_fb_mem (
  input  wire logic        aclk,
  input  wire logic        fb_rd,
  input  wire logic [31:0] fb_addr,
  output logic      [15:0] fb_rdata
);
  logic [15:0] junk;
  initial junk = 16'h0000;
  // ****************************************
  // Read answer
  // ****************************************
  always @(posedge aclk) begin
    junk <= ~junk;
  end
  // Valid at the edge after the strobe is raised
  assign fb_rdata = fb_rd ? (fb_addr[15:0] ^ 16'h5a5a) : junk;
endmodule

// ===== sim/lpt_timing_props.sv
// Purpose: Port-level checks of the panel timing generator
// Assumes: Raster enabled by software, never disabled mid-run
// Notes:   Bound to lpt_timing_gen
`timescale 1ns/1ns
module lpt_timing_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        panel_clk,
  input wire logic        timing_out_0,
  input wire logic        timing_out_1,
  input wire logic        timing_out_2,
  input wire logic [23:0] pix_rgb
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [16:0] hs_lo;
  logic [16:0] vs_lo;
  logic [13:0] ln_cnt;
  logic        seen;
  // ****************************************
  // Run-length helpers
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      hs_lo  <= 17'h0_0000;
      vs_lo  <= 17'h0_0000;
      ln_cnt <= 14'h0000;
      seen   <= 1'b0;
    end else begin
      hs_lo  <= timing_out_0 ? 17'h0_0000 : hs_lo + 17'h0_0001;
      vs_lo  <= timing_out_1 ? 17'h0_0000 : vs_lo + 17'h0_0001;
      ln_cnt <= (!timing_out_0 && hs_lo == 17'h0_0000) ? 14'h0001 : ln_cnt + 14'h0001;
      if (!timing_out_0)
        seen <= 1'b1;
    end
  end
  sequence pclk_hi4;
    panel_clk [*4];
  endsequence
  sequence pclk_lo4;
    !panel_clk [*4];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  pclk_div_a: assert property ($rose(panel_clk) |-> pclk_hi4 ##1 pclk_lo4 ##1 panel_clk)
    else $error("panel clock not aclk over eight");
  hsync_width_a: assert property ($rose(timing_out_0) |-> hs_lo == 17'd160)
    else $error("hsync low length wrong");
  vsync_width_a: assert property ($rose(timing_out_1) |-> vs_lo == 17'd81920)
    else $error("vsync low length wrong");
  line_total_a: assert property ($fell(timing_out_0) && $past(seen) |-> ln_cnt == 14'd8192)
    else $error("line period wrong");
  de_blank_a: assert property (timing_out_2 |-> timing_out_0 && timing_out_1)
    else $error("data enable during sync");
  blank_black_a: assert property (!timing_out_2 |-> pix_rgb == 24'h00_0000)
    else $error("blanking colour not black");
  frame_start_a: assert property ($fell(timing_out_1) |-> $fell(timing_out_0))
    else $error("vsync not at line start");
  hsync_stand_a: assert property ($changed(timing_out_0) |=> $stable(timing_out_0) [*7])
    else $error("hsync changed inside a panel period");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind lpt_timing_gen lpt_timing_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .panel_clk(panel_clk), .timing_out_0(timing_out_0),
  .timing_out_1(timing_out_1), .timing_out_2(timing_out_2), .pix_rgb(pix_rgb));

// ===== sim/lpt_timing_gen_test.sv
// Purpose: Register access and raster timing tests
// Assumes: Frame memory partner on the pixel read port
// Notes:   Runs ten lines, enough to see vsync end
`timescale 1ns/1ns
`include "lpt_defines.vh"
module lpt_timing_gen_test;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000, fb_addr, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fb_rd, panel_clk, to0, to1, to2;
  logic [1:0] bresp, rresp;
  logic [15:0] fb_rdata;
  logic [23:0] pix;
  integer n_mismatch = 0, compares = 0, cyc = 0, n, t0;
  always #5 aclk = ~aclk;
  lpt_timing_gen dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fb_addr(fb_addr),
    .fb_rd(fb_rd), .fb_rdata(fb_rdata), .panel_clk(panel_clk), .timing_out_0(to0),
    .timing_out_1(to1), .timing_out_2(to2), .pix_rgb(pix));
  lpt_fb_mem u_mem (.aclk(aclk), .fb_rd(fb_rd), .fb_addr(fb_addr), .fb_rdata(fb_rdata));
  // ****************************************
  // Helpers
  // ****************************************
  task wrap_up;
    begin
      if (n_mismatch == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task axi_wr(input [5:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    integer k;
    begin
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (k = 0; k < 50; k = k + 1) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          chk(bresp, er);
          bready <= 1'b0;
          k = 50;
        end
      end
      @(posedge aclk);
    end
  endtask
  task axi_rd(input [5:0] a, input [31:0] ed, input [31:0] mask, input [1:0] er);
    integer k;
    begin
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (k = 0; k < 50; k = k + 1) begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          chk(rresp, er);
          chk(rdata & mask, ed);
          rready <= 1'b0;
          k = 50;
        end
      end
      @(posedge aclk);
    end
  endtask
  function logic pick(input integer s);
    case (s)
      0: pick = to0;
      1: pick = to1;
      default: pick = panel_clk;
    endcase
  endfunction
  task run_len(input integer s, input logic lvl);
    begin
      n = 0;
      while (pick(s) === lvl && n < 90000) begin
        @(posedge aclk);
        n = n + 1;
      end
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({to2, to1, to0, panel_clk}, 32'h0000_0006);
    axi_rd(`LPT_REG_CTRL, `LPT_CTRL_RESET, 32'hffff_ffff, `LPT_RESP_OKAY);
    axi_rd(`LPT_REG_ADJ, `LPT_ADJ_RESET, 32'h0000_ffff, `LPT_RESP_OKAY);
    axi_rd(6'h18, 32'h0000_0000, 32'hffff_ffff, `LPT_RESP_DECERR);
    axi_wr(6'h1c, 32'h0000_1234, 4'hf, `LPT_RESP_DECERR);
    axi_wr(`LPT_REG_BUF0, 32'h0001_2340, 4'hf, `LPT_RESP_OKAY);
    axi_wr(`LPT_REG_BUF1, 32'h0002_5680, 4'hf, `LPT_RESP_OKAY);
    axi_rd(`LPT_REG_BUF0, 32'h0001_2340, 32'hffff_ffff, `LPT_RESP_OKAY);
    axi_rd(`LPT_REG_BUF1, 32'h0002_5680, 32'hffff_ffff, `LPT_RESP_OKAY);
    axi_wr(`LPT_REG_ADJ, 32'h0000_9910, 4'h1, `LPT_RESP_OKAY);
    axi_rd(`LPT_REG_ADJ, 32'h0000_8010, 32'h0000_ffff, `LPT_RESP_OKAY);
    axi_wr(`LPT_REG_FRAMES, 32'h0000_0055, 4'hf, `LPT_RESP_OKAY);
    axi_rd(`LPT_REG_FRAMES, 32'h0000_0000, 32'hffff_ffff, `LPT_RESP_OKAY);
    axi_wr(`LPT_REG_CTRL, 32'h0000_0007, 4'hf, `LPT_RESP_OKAY);
    axi_rd(`LPT_REG_CTRL, 32'h0000_0007, 32'h0000_001f, `LPT_RESP_OKAY);
    run_len(0, 1'b1);
    t0 = cyc;
    chk(to1, 32'h0000_0000);
    run_len(0, 1'b0);
    chk(n, 160);
    run_len(0, 1'b1);
    chk(n, 8192 - 160);
    chk(to2, 32'h0000_0000);
    run_len(2, 1'b0);
    run_len(2, 1'b1);
    chk(n, 4);
    run_len(2, 1'b0);
    chk(n, 4);
    run_len(1, 1'b0);
    chk(cyc - t0, 81920);
    axi_rd(`LPT_REG_STATUS, 32'h0000_000a, 32'h0002_03ff, `LPT_RESP_OKAY);
    wrap_up;
  end
endmodule
